// File: rtl/uart_lin_pkg.sv
// Package: register map, field layout, reset values and counts for the LIN-capable UART
// ----------------------------------------------------------------------
// What this block does
// R1: Control bit enables LIN master lengthened break
// R2: Break low bits: 10, 11, 13, 14
// R3: Data port: write TX holding, read RX holding
// R4: First prescaler divides by 1, 3, 4, 13
// R5: TX coarse divisor is two to field
// R6: RX coarse divisor is two to field
// R7: TX fine zero uses coarse alone, else product
// R8: RX fine zero uses coarse alone, else product
// R9: RX fine divides post-16 clock by value
// R10: TX fine divides post-16 clock by value
// R11: Both fine dividers reset to zero
// R12: LIN control resets zero, only bit 6 used
// R13: Break request then release sends one break word
// R14: Word length bit selects 8 or 9 data bits
// R15: Bit rate is clock over prescaler, 16, divisor
// ----------------------------------------------------------------------
package uart_lin_pkg;

  // --------------------------------------------------------------------
  // Register indices (printed offsets are not word aligned)
  // --------------------------------------------------------------------
  localparam logic [7:0] IDX_DATA      = 8'hF1;
  localparam logic [7:0] IDX_BAUD      = 8'hF2;
  localparam logic [7:0] IDX_RX_FINE   = 8'hF5;
  localparam logic [7:0] IDX_TX_FINE   = 8'hF6;
  localparam logic [7:0] IDX_BRK_MODE  = 8'hFF;
  // Own registers: frame control and status
  localparam logic [7:0] IDX_CTRL      = 8'hF3;
  localparam logic [7:0] IDX_STATUS    = 8'hF4;
  localparam int         ADDR_W        = 12;

  // --------------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------------
  localparam int         LIN_EN_BIT    = 6;
  localparam int         CTRL_BRK_BIT  = 0;
  localparam int         CTRL_RXEN_BIT = 1;
  localparam int         CTRL_TXEN_BIT = 2;
  localparam int         CTRL_WL_BIT   = 3;
  localparam int         CTRL_T8_BIT   = 4;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_BAUD      = 8'h00;
  localparam logic [7:0] BRK_MODE_MASK = 8'h40;

  // --------------------------------------------------------------------
  // Counts
  // --------------------------------------------------------------------
  localparam logic [4:0] BRK_BITS_STD   = 5'd10;
  localparam logic [4:0] BRK_BITS_STD9  = 5'd11;
  localparam logic [4:0] BRK_BITS_LIN   = 5'd13;
  localparam logic [4:0] BRK_BITS_LIN9  = 5'd14;
  localparam logic [4:0] OVERSAMPLE     = 5'd16;
  localparam logic [3:0] FRAME_BITS_8   = 4'd10;
  localparam logic [3:0] FRAME_BITS_9   = 4'd11;
  localparam logic [1:0] AXI_OKAY       = 2'b00;
  localparam logic [1:0] AXI_SLVERR     = 2'b10;

  // Baud configuration carrier
  typedef struct packed {
    logic [1:0] firstPrescalerSel;
    logic [2:0] txRateDivisorSel;
    logic [2:0] rxRateDivisorSel;
  } baud_sel_s;

  // Frame word carried through the FIFO
  typedef struct packed {
    logic       bit8;
    logic [7:0] data;
  } word_s;

  // First prescaler factor from its select field
  function automatic logic [3:0] prescale_factor(input logic [1:0] sel);
    case (sel)
      2'b00:   prescale_factor = 4'd1;
      2'b01:   prescale_factor = 4'd3;
      2'b10:   prescale_factor = 4'd4;
      default: prescale_factor = 4'd13;
    endcase
  endfunction : prescale_factor

  // Coarse times fine division; fine zero means coarse alone
  function automatic logic [15:0] rate_divide(input logic [2:0] sel, input logic [7:0] fine);
    logic [15:0] coarse;
    coarse = 16'd1 << sel;
    rate_divide = (fine == 8'h00) ? coarse : 16'(coarse * fine);
  endfunction : rate_divide

endpackage : uart_lin_pkg

// File: rtl/uart_word_fifo.sv
// Word FIFO with valid/ready on both sides
`timescale 1ns/10ps
module uart_word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wrPtr;
  logic [AW-1:0]    next_rdPtr;
  logic [AW:0]      next_count;
  logic             doWr;
  logic             doRd;

  // Pointer and fill bookkeeping
  always_comb begin
    doWr       = inValid && inReady;
    doRd       = outValid && outReady;
    next_wrPtr = doWr ? AW'(wrPtr + 1'b1) : wrPtr;
    next_rdPtr = doRd ? AW'(rdPtr + 1'b1) : rdPtr;
    next_count = count + (AW+1)'(doWr) - (AW+1)'(doRd);
  end

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];

  // Registers only; storage has no reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (clkEn) begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clkEn && doWr) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule : uart_word_fifo

// File: rtl/uart_lin_top.sv
// UART baud generator, LIN break control and data path behind AXI4-Lite
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
module uart_lin_top
  import uart_lin_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                clkEn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                rxd,
  output logic                     txd
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  baud_sel_s   baudSel;
  logic [7:0]  rxFineDivisor;
  logic [7:0]  txFineDivisor;
  logic [7:0]  breakModeControl;
  logic [7:0]  ctrl;
  logic [7:0]  rxHoldingReg;
  logic        rxHoldBit8;
  logic        rxFull;
  logic        rxOverrun;
  logic        awHeld;
  logic        wHeld;
  logic [ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;

  logic        linEnable;
  logic        wordLen9;
  logic        sendBreak;
  assign linEnable = breakModeControl[LIN_EN_BIT];
  assign wordLen9  = ctrl[CTRL_WL_BIT];
  assign sendBreak = ctrl[CTRL_BRK_BIT];

  // ----------------------------------------------------------------------
  // Baud generation: prescaler, then coarse*fine, then 16x ticks
  // ----------------------------------------------------------------------
  logic [3:0]  preCnt;
  logic        preTick;
  logic [15:0] txDivCnt;
  logic [15:0] rxDivCnt;
  logic        txTick16;
  logic        rxTick16;
  logic [3:0]  txSub;
  logic        txBitTick;
  // Rewriting a divider restarts the prescaler and both divider counters, so a smaller divide never overshoots
  logic        divLoad;

  // First prescaler common to both directions
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      preCnt <= '0;
    end else if (divLoad) begin
      preCnt <= '0;
    end else if (clkEn) begin
      preCnt <= (preCnt + 4'd1 >= prescale_factor(baudSel.firstPrescalerSel)) ? 4'd0
                : 4'(preCnt + 4'd1);                                    // [R4]
    end
  end
  assign preTick = clkEn && (4'(preCnt + 4'd1) >= prescale_factor(baudSel.firstPrescalerSel));

  // Coarse and fine division per direction
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txDivCnt <= '0;
      rxDivCnt <= '0;
    end else if (divLoad) begin
      txDivCnt <= '0;
      rxDivCnt <= '0;
    end else if (preTick) begin
      txDivCnt <= txTick16 ? 16'd0 : 16'(txDivCnt + 16'd1);   // [R5] [R7] [R10]
      rxDivCnt <= rxTick16 ? 16'd0 : 16'(rxDivCnt + 16'd1);   // [R6] [R8] [R9]
    end
  end
  assign txTick16 = preTick
    && (16'(txDivCnt + 16'd1) >= rate_divide(baudSel.txRateDivisorSel, txFineDivisor));
  assign rxTick16 = preTick
    && (16'(rxDivCnt + 16'd1) >= rate_divide(baudSel.rxRateDivisorSel, rxFineDivisor));

  // Sixteen ticks make one transmit bit time
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txSub <= '0;
    end else if (txTick16) begin
      txSub <= 4'(txSub + 4'd1);                                 // [R15]
    end
  end
  assign txBitTick = txTick16 && (txSub == 4'hF);

  // ----------------------------------------------------------------------
  // Transmit FIFO feeding the shifter
  // ----------------------------------------------------------------------
  word_s       fifoIn;
  word_s       fifoOut;
  logic        fifoInValid;
  logic        fifoInReady;
  logic        fifoOutValid;
  logic        fifoOutReady;

  uart_word_fifo #(.WIDTH($bits(word_s)), .DEPTH(FIFO_DEPTH)) txFifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clkEn    (clkEn),
    .inData   (fifoIn),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady)
  );

  // ----------------------------------------------------------------------
  // Transmitter: data frames and break words
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_DATA  = 3'b010,
    TX_BREAK = 3'b100
  } tx_state_e;
  tx_state_e   txState;
  tx_state_e   next_txState;
  logic [10:0] txShift;
  logic [10:0] next_txShift;
  logic [4:0]  txBitsLeft;
  logic [4:0]  next_txBitsLeft;
  logic        breakArmed;
  logic        next_breakArmed;
  logic        sendBreakLast;
  logic        next_txd;

  // Break length from LIN enable and word length
  function automatic logic [4:0] break_bits(input logic lin, input logic nine);
    case ({lin, nine})
      2'b00:   break_bits = BRK_BITS_STD;
      2'b01:   break_bits = BRK_BITS_STD9;
      2'b10:   break_bits = BRK_BITS_LIN;
      default: break_bits = BRK_BITS_LIN9;
    endcase
  endfunction : break_bits

  // A set-then-clear of the break bit arms one break after the current word
  always_comb begin
    next_txState    = txState;
    next_txShift    = txShift;
    next_txBitsLeft = txBitsLeft;
    next_breakArmed = breakArmed || (sendBreakLast && !sendBreak);        // [R13]
    next_txd        = txd;
    fifoOutReady    = 1'b0;
    case (txState)
      TX_IDLE: begin
        next_txd = 1'b1;
        if (txBitTick && ctrl[CTRL_TXEN_BIT]) begin
          if (next_breakArmed) begin
            next_breakArmed = 1'b0;
            next_txState    = TX_BREAK;
            next_txBitsLeft = break_bits(linEnable, wordLen9);   // [R1] [R2]
            next_txd        = 1'b0;
          end else if (fifoOutValid) begin
            fifoOutReady    = 1'b1;
            next_txState    = TX_DATA;
            next_txd        = 1'b0;                    // Start bit from the first cycle
            // Start bit first, then LSB first, stop bit last
            next_txShift    = wordLen9 ? {1'b1, fifoOut.bit8, fifoOut.data, 1'b0}
                                       : {2'b11, fifoOut.data, 1'b0};          // [R14]
            next_txBitsLeft = wordLen9 ? 5'(FRAME_BITS_9) : 5'(FRAME_BITS_8);
          end
        end
      end
      TX_DATA: begin
        next_txd = txShift[0];
        if (txBitTick) begin
          next_txShift    = {1'b1, txShift[10:1]};
          next_txBitsLeft = 5'(txBitsLeft - 5'd1);
          next_txd        = txShift[1];
          if (txBitsLeft == 5'd1) begin
            next_txState = TX_IDLE;
            next_txd     = 1'b1;
          end
        end
      end
      TX_BREAK: begin
        next_txd = 1'b0;
        if (txBitTick) begin
          next_txBitsLeft = 5'(txBitsLeft - 5'd1);
          if (txBitsLeft == 5'd1) begin
            next_txState = TX_IDLE;                              // stop bit follows
            next_txd     = 1'b1;
          end
        end
      end
      default: begin
        next_txState = TX_IDLE;
        next_txd     = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txState       <= TX_IDLE;
      txShift       <= '1;
      txBitsLeft    <= '0;
      breakArmed    <= 1'b0;
      sendBreakLast <= 1'b0;
      txd           <= 1'b1;
    end else if (clkEn) begin
      txState       <= next_txState;
      txShift       <= next_txShift;
      txBitsLeft    <= next_txBitsLeft;
      breakArmed    <= next_breakArmed;
      sendBreakLast <= sendBreak;
      txd           <= next_txd;
    end
  end

  // ----------------------------------------------------------------------
  // Receiver: 16x oversampling, mid-bit sampling
  // ----------------------------------------------------------------------
  logic [3:0]  rxSub;
  logic [3:0]  rxBitIdx;
  logic [8:0]  rxShift;
  logic        rxBusy;
  logic        rxDone;
  logic [3:0]  rxLastIdx;
  assign rxLastIdx = wordLen9 ? 4'd10 : 4'd9;

  // Frame capture into the shifter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxSub    <= '0;
      rxBitIdx <= '0;
      rxShift  <= '0;
      rxBusy   <= 1'b0;
    end else if (rxTick16 && ctrl[CTRL_RXEN_BIT]) begin
      if (!rxBusy) begin
        rxSub    <= '0;
        rxBitIdx <= '0;
        rxBusy   <= !rxd;
      end else begin
        rxSub <= 4'(rxSub + 4'd1);
        if (rxSub == 4'd7) begin
          rxBitIdx <= 4'(rxBitIdx + 4'd1);
          if (rxBitIdx == 4'd0 && rxd) begin
            rxBusy <= 1'b0;                                   // false start
          end else if (rxBitIdx == rxLastIdx) begin
            rxBusy <= 1'b0;
          end else if (rxBitIdx != 4'd0) begin
            rxShift <= wordLen9 ? {rxd, rxShift[8:1]} : {1'b0, rxd, rxShift[7:1]};
          end
        end
      end
    end
  end
  assign rxDone = rxTick16 && ctrl[CTRL_RXEN_BIT] && rxBusy && rxSub == 4'd7
                  && rxBitIdx == rxLastIdx;

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic [7:0]  wrIdx;
  logic [7:0]  rdIdx;
  logic        doWrite;
  logic        doRead;
  logic        wrHit;
  logic        rdHit;
  logic [7:0]  rdByte;
  assign wrIdx   = awAddr[9:2];
  assign rdIdx   = s_axi_araddr[9:2];
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign doRead  = s_axi_arvalid && s_axi_arready;
  assign wrHit   = awAddr[ADDR_W-1:10] == '0 && (wrIdx == IDX_DATA || wrIdx == IDX_BAUD
    || wrIdx == IDX_RX_FINE || wrIdx == IDX_TX_FINE || wrIdx == IDX_BRK_MODE
    || wrIdx == IDX_CTRL || wrIdx == IDX_STATUS);
  assign rdHit   = s_axi_araddr[ADDR_W-1:10] == '0 && (rdIdx == IDX_DATA || rdIdx == IDX_BAUD
    || rdIdx == IDX_RX_FINE || rdIdx == IDX_TX_FINE || rdIdx == IDX_BRK_MODE
    || rdIdx == IDX_CTRL || rdIdx == IDX_STATUS);
  // Data write waits while the FIFO is full: back-pressure stalls the bus
  assign fifoIn      = '{bit8: ctrl[CTRL_T8_BIT], data: wData[7:0]};
  assign fifoInValid = doWrite && wrIdx == IDX_DATA && wrHit && wStrb[0];
  // Accepted write to a divider register
  assign divLoad     = clkEn && doWrite && wrHit && wStrb[0]
    && (wrIdx == IDX_BAUD || wrIdx == IDX_RX_FINE || wrIdx == IDX_TX_FINE);

  // Read mux
  always_comb begin
    case (rdIdx)
      IDX_DATA:     rdByte = rxHoldingReg;                                  // [R3]
      IDX_BAUD:     rdByte = baudSel;
      IDX_RX_FINE:  rdByte = rxFineDivisor;
      IDX_TX_FINE:  rdByte = txFineDivisor;
      IDX_BRK_MODE: rdByte = breakModeControl;
      IDX_CTRL:     rdByte = ctrl;
      IDX_STATUS:   rdByte = {4'h0, rxHoldBit8, rxOverrun, fifoInReady, rxFull};
      default:      rdByte = 8'h00;
    endcase
  end

  // Bus handshakes, register writes and receive holding
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHeld           <= 1'b0;
      wHeld            <= 1'b0;
      awAddr           <= '0;
      wData            <= '0;
      wStrb            <= '0;
      s_axi_awready    <= 1'b1;
      s_axi_wready     <= 1'b1;
      s_axi_bvalid     <= 1'b0;
      s_axi_bresp      <= AXI_OKAY;
      s_axi_arready    <= 1'b1;
      s_axi_rvalid     <= 1'b0;
      s_axi_rdata      <= '0;
      s_axi_rresp      <= AXI_OKAY;
      baudSel          <= RST_BAUD;
      rxFineDivisor    <= RST_ZERO;                                         // [R11]
      txFineDivisor    <= RST_ZERO;                                         // [R11]
      breakModeControl <= RST_ZERO;                                         // [R12]
      ctrl             <= RST_ZERO;
      rxHoldingReg     <= RST_ZERO;
      rxHoldBit8       <= 1'b0;
      rxFull           <= 1'b0;
      rxOverrun        <= 1'b0;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld        <= 1'b1;
        awAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld        <= 1'b1;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite && !(fifoInValid && !fifoInReady)) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? AXI_OKAY : AXI_SLVERR;
        if (wrHit && wStrb[0]) begin
          case (wrIdx)
            IDX_BAUD:     baudSel          <= wData[7:0];
            IDX_RX_FINE:  rxFineDivisor    <= wData[7:0];
            IDX_TX_FINE:  txFineDivisor    <= wData[7:0];
            IDX_BRK_MODE: breakModeControl <= wData[7:0] & BRK_MODE_MASK;   // [R12]
            IDX_CTRL:     ctrl             <= {3'b000, wData[4:0]};
            default:      ;
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (doRead) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rdByte};
        s_axi_rresp   <= rdHit ? AXI_OKAY : AXI_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      // New word wins over a clearing data read in the same cycle
      if (doRead && rdHit && rdIdx == IDX_DATA) begin
        rxFull    <= 1'b0;
        rxOverrun <= 1'b0;
      end
      if (rxDone) begin
        if (rxFull && !(doRead && rdIdx == IDX_DATA)) begin
          rxOverrun <= 1'b1;                                   // holding kept
        end else begin
          rxHoldingReg <= rxShift[7:0];                                     // [R3]
          rxHoldBit8   <= rxShift[8];
          rxFull       <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_fine_reset;
    @(posedge ref_clk) $fell(rst) |-> rxFineDivisor == 8'h00 && txFineDivisor == 8'h00;
  endproperty
  a_fine_reset: assert property (p_fine_reset) else $error("fine dividers not zero"); // [R11]

  property p_lin_reserved;
    @(posedge ref_clk) disable iff (rst) (breakModeControl & 8'hBF) == 8'h00;
  endproperty
  a_lin_reserved: assert property (p_lin_reserved) else $error("reserved bits set"); // [R12]

  property p_break_len;
    @(posedge ref_clk) disable iff (rst)
      (txState == TX_IDLE ##1 txState == TX_BREAK) |->
        txBitsLeft == break_bits(linEnable, wordLen9);
  endproperty
  a_break_len: assert property (p_break_len) else $error("wrong break length"); // [R1] [R2]

  property p_break_low;
    @(posedge ref_clk) disable iff (rst) txState == TX_BREAK |-> !txd;
  endproperty
  a_break_low: assert property (p_break_low) else $error("break not low"); // [R13]

  property p_div_tx;
    @(posedge ref_clk) disable iff (rst)
      txTick16 |-> 16'(txDivCnt + 16'd1) == (txFineDivisor == 8'h00
        ? (16'd1 << baudSel.txRateDivisorSel)
        : 16'((16'd1 << baudSel.txRateDivisorSel) * txFineDivisor));
  endproperty
  a_div_tx: assert property (p_div_tx) else $error("tx divisor wrong"); // [R5] [R7] [R10]

  property p_prescale;
    @(posedge ref_clk) disable iff (rst)
      preTick |-> preCnt == 4'(prescale_factor(baudSel.firstPrescalerSel) - 4'd1);
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler count wrong"); // [R4]

  property p_rx_hold;
    @(posedge ref_clk) disable iff (rst)
      (clkEn && rxDone && !rxFull) |=> rxFull && rxHoldingReg == $past(rxShift[7:0]);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx holding not loaded"); // [R3] [R6]

  property p_idle_high;
    @(posedge ref_clk) disable iff (rst) (txState == TX_IDLE && $past(txState) == TX_IDLE)
      |-> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle line low"); // [R14]

endmodule : uart_lin_top

// File: verif/uart_remote_node.sv
// Remote serial node: drives the receive line and times low runs on transmit
`timescale 1ns/10ps
module uart_remote_node (
  input  wire logic        ref_clk,
  input  wire logic        txd,
  output logic             rxd,
  output logic [15:0]      lowRun,
  output logic [7:0]       runs
);
  logic [15:0] cnt = 16'h0000;
  initial rxd = 1'b1;
  initial runs = 8'h00;
  initial lowRun = 16'h0000;
  // Latch each low stretch when the line returns high
  always @(posedge ref_clk) begin
    if (!txd) cnt <= cnt + 16'h0001;
    else if (cnt != 16'h0000) begin
      lowRun <= cnt;
      runs   <= runs + 8'h01;
      cnt    <= 16'h0000;
    end
  end
  // One 8-bit frame, LSB first; line idles high, as with a pull-up
  task automatic send(input logic [7:0] b, input int bitClk);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bitClk) @(posedge ref_clk);
    end
  endtask : send
endmodule : uart_remote_node

// File: verif/testbench.sv
// Self-checking bench for the UART baud, break and data path
`timescale 1ns/10ps
module testbench;
  import uart_lin_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, clkEn = 1'b1, rxd, txd;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] lowRun;
  logic [7:0] runs, r0;
  int num_errors = 0, checks = 0;
  // Row: address, value written, value read back
  logic [11:0] ra [4] = '{12'h3FC, 12'h3C8, 12'h3D4, 12'h3D8};
  logic [7:0] rw [4] = '{8'hFF, 8'hA5, 8'h7E, 8'h81};
  logic [7:0] rx [4] = '{8'h40, 8'hA5, 8'h7E, 8'h81};
  always #10 ref_clk = ~ref_clk;
  uart_lin_top u_dut (.*);
  uart_remote_node u_node (.ref_clk(ref_clk), .txd(txd), .rxd(rxd), .lowRun(lowRun), .runs(runs));
  // ----------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    // Response readies stay high, so back-to-back calls never reassign them in one step
  endtask : wr
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
  endtask : rd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Waits for the node to time the next low stretch
  task automatic low_run(input string n, input logic [15:0] e);
    r0 = runs;
    while (runs == r0) @(posedge ref_clk);
    chk(n, {16'h0000, e}, {16'h0000, lowRun});
  endtask : low_run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    foreach (ra[i]) begin
      wr(ra[i], rw[i]);
      rd(ra[i]);
      chk("reg", {24'h00_0000, rx[i]}, d);
    end
    $display("test registers done");
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reset", 32'h0000_0000, d);
    end
    rd(12'h3E0);
    chk("unmapped", {30'h0000_0000, 2'b10}, {30'h0000_0000, s_axi_rresp});
    wr(12'h3E0, 8'h00);
    chk("unmapped wr", {30'h0000_0000, 2'b10}, {30'h0000_0000, s_axi_bresp});
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      wr(12'h3FC, k[1] ? 8'h40 : 8'h00);
      wr(12'h3CC, k[0] ? 8'h0C : 8'h04);
      wr(12'h3CC, k[0] ? 8'h0D : 8'h05);
      wr(12'h3CC, k[0] ? 8'h0C : 8'h04);
      low_run("break", 16'((10 + k[0] + 3 * k[1]) * 16));
    end
    $display("test break done");
    wr(12'h3FC, 8'h00);
    wr(12'h3CC, 8'h04);
    wr(12'h3C8, 8'h48);
    wr(12'h3D8, 8'h02);
    wr(12'h3C4, 8'h00);
    low_run("rate", 16'd1728);
    $display("test rate done");
    wr(12'h3C8, 8'h00);
    wr(12'h3CC, 8'h06);
    u_node.send(8'h5A, 16);
    repeat (20) @(posedge ref_clk);
    rd(12'h3C4);
    chk("rx data", 32'h0000_005A, d);
    $display("test receive done");
    wrap_up;
  end
  // Watchdog sized well above the longest sequence
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    wrap_up;
  end
endmodule : testbench
